// ==== src/close_fault_guard.sv ====
// Purpose: Switch-onto-fault guard with modes, events, counters and record log
// Assumes: Inputs synchronous to sys_clk; Wishbone slave
// Notes: Trip follows func_in combinationally in the window, except in the two test modes; forced status overrides it
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps

// Notes on behaviour
// (R1) Arm only on rising edge of arm input
// (R2) Trip at once on function input in window
// (R3) Release time in ms, max 1800 s, default 1 s
// (R4) Block input stops start, reports blocked
// (R5) Setting group change alters running release time
// (R6) Five operating modes, settable only when allowed
// (R7) Forced status normal/blocked/active/trip when enabled
// (R8) Condition: normal, init, active, trip, blocked
// (R9) Stamped ON/OFF events, ON/OFF/both selectable
// (R10) Resettable counters for init, block, active, trip
// (R11) Twelve newest records, oldest overwritten first
// (R12) Record: stamp, event, group, remaining, active time
// (R13) New rising edge restarts full release time
module close_fault_guard
    import close_fault_guard_pkg::*;
#(
    parameter int FUNC_WIDTH = 8,
    parameter int CYCLES_PER_MS = CYC_PER_MS
) (
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic [7:0] wb_adr, // Wishbone byte address
    input wire logic wb_cyc, // Wishbone cycle
    input wire logic wb_stb, // Wishbone strobe
    input wire logic wb_we, // Wishbone write enable
    input wire logic [3:0] wb_sel, // Wishbone byte lanes
    input wire logic [31:0] wb_wdat, // Wishbone write data
    output logic [31:0] wb_rdat, // Wishbone read data
    output logic wb_ack, // Wishbone acknowledge
    input wire logic arm_in, // Arming input
    input wire logic block_in, // Block input
    input wire logic [FUNC_WIDTH-1:0] func_in, // Stage starts
    input wire logic [2:0] setting_group, // Active setting group, 0 = group 1
    output logic guard_trip, // Instant trip output
    output logic guard_window, // Release window running
    output logic [2:0] condition, // Condition status code
    output logic [3:0] evt_on, // ON event pulses: init, block, active, trip
    output logic [3:0] evt_off, // OFF event pulses, same order
    output logic [31:0] evt_stamp, // Stamp of event pulses, ms
    output logic irq // Level interrupt
);
    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    generate
        if (FUNC_WIDTH < 1 || FUNC_WIDTH > 32)
        begin : g_bad_width
            $error("close_fault_guard: FUNC_WIDTH must be 1 to 32");
        end
    endgenerate

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic arm_prev;
        logic win;
        logic init;
        logic [TW-1:0] elapsed;
        logic [3:0] lv;
        logic [2:0] mode;
        logic mode_allow;
        logic force_en;
        logic [1:0] force_val;
        logic [1:0] evt_sel;
        logic [GROUPS-1:0][TW-1:0] rel;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [3:0][15:0] cnt;
        record_t [RECORDS-1:0] recs;
        logic [3:0] wptr;
        logic [3:0] rnum;
        logic [3:0] rsel;
        logic [31:0] time_ms;
        logic ack;
        logic [31:0] dat;
        logic [3:0] ev_on;
        logic [3:0] ev_off;
        logic [31:0] ev_stamp;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic ms_tick;

    ms_tick_gen #(
        .CYCLES(CYCLES_PER_MS)
    ) u_tick (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tick(ms_tick)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[b*8 +: 8] = wd[b*8 +: 8];
        end
        return r;
    endfunction : wmerge

    // Record index age steps before newest
    function automatic logic [3:0] rec_index(input logic [3:0] wptr, input logic [3:0] age);
        logic [4:0] idx;
        idx = 5'(wptr) + 5'(RECORDS) - 5'd1 - 5'(age);
        if (idx >= 5'(RECORDS))
            idx = idx - 5'(RECORDS);
        return idx[3:0];
    endfunction : rec_index

    function automatic logic [31:0] rel_clip(input logic [31:0] v);
        return (v[TW-1:0] > RELEASE_MAX_MS || |v[31:TW]) ? 32'(RELEASE_MAX_MS) : v;
    endfunction : rel_clip

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic arm_rise;
    logic mode_blk;
    logic mode_off;
    logic mode_test;
    logic start;
    logic [2:0] eff_mode;
    logic [TW-1:0] rel_cur;
    logic [TW-1:0] remain;
    logic [3:0] lv_now;
    logic [3:0] on_raw;
    logic [3:0] off_raw;
    logic [3:0] w1c;
    logic [3:0] cclr;
    logic [3:0] ridx;
    logic bus_req;
    logic [31:0] wv;
    record_t rec_new;
    record_t rec_rd;

    always_comb
    begin
        st_nxt = st_r;
        eff_mode = st_r.mode_allow ? st_r.mode : MODE_ON; // R6
        mode_blk = (eff_mode == MODE_BLOCKED) || (eff_mode == MODE_TEST_BLOCKED);
        mode_off = (eff_mode == MODE_OFF);
        mode_test = (eff_mode == MODE_TEST) || (eff_mode == MODE_TEST_BLOCKED);
        rel_cur = st_r.rel[setting_group]; // R5
        arm_rise = arm_in && !st_r.arm_prev; // R1
        start = arm_rise && !block_in && !mode_blk && !mode_off; // R4
        st_nxt.arm_prev = arm_in;
        st_nxt.time_ms = st_r.time_ms + (ms_tick ? 32'd1 : 32'd0);

        // End checked against live group value
        if (mode_blk || mode_off)
        begin
            st_nxt.win = 1'b0;
            st_nxt.init = 1'b0;
            st_nxt.elapsed = '0;
        end
        else if (start)
        begin
            st_nxt.win = 1'b1; // R1
            st_nxt.init = 1'b1;
            st_nxt.elapsed = '0; // R13
        end
        else
        begin
            st_nxt.init = 1'b0;
            if (st_r.win && st_r.elapsed >= rel_cur)
                st_nxt.win = 1'b0; // R3
            else if (st_r.win && ms_tick)
                st_nxt.elapsed = st_r.elapsed + TW'(1); // R3
        end
        remain = (st_r.win && rel_cur > st_r.elapsed) ? rel_cur - st_r.elapsed : '0;

        // Levels of the four reported states
        lv_now[EV_INIT] = st_r.init;
        lv_now[EV_BLOCK] = block_in || mode_blk; // R4
        lv_now[EV_ACTIVE] = st_r.win && !st_r.init;
        lv_now[EV_TRIP] = st_r.win && |func_in; // R2
        if (st_r.force_en) // R7
        begin
            lv_now = '0;
            case (st_r.force_val)
                FORCE_BLOCKED: lv_now[EV_BLOCK] = 1'b1;
                FORCE_ACTIVE: lv_now[EV_ACTIVE] = 1'b1;
                FORCE_TRIP: lv_now[EV_TRIP] = 1'b1;
                default: lv_now = '0;
            endcase
        end
        if (mode_off)
            lv_now = '0; // R6
        st_nxt.lv = lv_now;
        on_raw = lv_now & ~st_r.lv; // R9
        off_raw = st_r.lv & ~lv_now; // R9
        st_nxt.ev_on = on_raw & {4{st_r.evt_sel[0]}}; // R9
        st_nxt.ev_off = off_raw & {4{st_r.evt_sel[1]}}; // R9
        if (|(on_raw | off_raw))
            st_nxt.ev_stamp = st_r.time_ms; // R9

        // Record on block, active or trip ON edges, highest state wins
        rec_new.stamp = st_r.time_ms; // R12
        rec_new.event_code = on_raw[EV_TRIP] ? COND_TRIP : on_raw[EV_ACTIVE] ? COND_ACTIVE : COND_BLOCKED;
        rec_new.group = setting_group; // R12
        rec_new.remain = remain; // R12
        rec_new.active = st_r.elapsed; // R12
        if (|on_raw[EV_TRIP:EV_BLOCK])
        begin
            st_nxt.recs[st_r.wptr] = rec_new; // R11
            st_nxt.wptr = (st_r.wptr == 4'(RECORDS - 1)) ? 4'd0 : st_r.wptr + 4'd1; // R11
            if (st_r.rnum != 4'(RECORDS))
                st_nxt.rnum = st_r.rnum + 4'd1;
        end

        // One wait state; ack is a one-cycle pulse
        bus_req = wb_cyc && wb_stb && !st_r.ack;
        st_nxt.ack = bus_req;
        w1c = '0;
        cclr = '0;
        wv = '0;
        ridx = rec_index(st_r.wptr, st_r.rsel);
        rec_rd = st_r.recs[ridx];
        if (bus_req && wb_we)
        begin
            case (wb_adr)
                REG_CTRL:
                begin
                    wv = wmerge({23'h0, st_r.evt_sel, st_r.force_val, st_r.force_en, st_r.mode_allow,
                        st_r.mode}, wb_wdat, wb_sel);
                    st_nxt.mode_allow = wv[CTRL_ALLOW];
                    if (st_r.mode_allow && wv[CTRL_MODE +: 3] <= MODE_OFF)
                        st_nxt.mode = wv[CTRL_MODE +: 3]; // R6
                    st_nxt.force_en = wv[CTRL_FORCE_EN];
                    st_nxt.force_val = wv[CTRL_FORCE +: 2]; // R7
                    st_nxt.evt_sel = wv[CTRL_EVT_SEL +: 2]; // R9
                end
                REG_IRQ_STAT: w1c = wb_sel[0] ? wb_wdat[3:0] : 4'h0;
                REG_IRQ_MASK: if (wb_sel[0]) st_nxt.irq_mask = wb_wdat[3:0];
                REG_CNT_CLR: cclr = wb_sel[0] ? wb_wdat[3:0] : 4'h0; // R10
                REG_REC_SEL: if (wb_sel[0] && wb_wdat[3:0] < 4'(RECORDS)) st_nxt.rsel = wb_wdat[3:0];
                default:
                begin
                    if (wb_adr[7:5] == REG_RELEASE[7:5])
                    begin
                        wv = rel_clip(wmerge(32'(st_r.rel[wb_adr[4:2]]), wb_wdat, wb_sel)); // R3
                        st_nxt.rel[wb_adr[4:2]] = wv[TW-1:0];
                    end
                end
            endcase
        end
        if (bus_req && !wb_we)
        begin
            case (wb_adr)
                REG_CTRL: st_nxt.dat = {23'h0, st_r.evt_sel, st_r.force_val, st_r.force_en,
                    st_r.mode_allow, st_r.mode};
                REG_STATUS: st_nxt.dat = {21'h0, setting_group, lv_now[EV_TRIP] && !mode_test, st_r.win,
                    eff_mode, condition};
                REG_IRQ_STAT: st_nxt.dat = {28'h0, st_r.irq_stat};
                REG_IRQ_MASK: st_nxt.dat = {28'h0, st_r.irq_mask};
                REG_TIME: st_nxt.dat = st_r.time_ms;
                REG_CNT_LO: st_nxt.dat = {st_r.cnt[EV_BLOCK], st_r.cnt[EV_INIT]};
                REG_CNT_HI: st_nxt.dat = {st_r.cnt[EV_TRIP], st_r.cnt[EV_ACTIVE]};
                REG_REC_SEL: st_nxt.dat = {28'h0, st_r.rsel};
                REG_REC_NUM: st_nxt.dat = {28'h0, st_r.rnum};
                REG_REC_STAMP: st_nxt.dat = rec_rd.stamp;
                REG_REC_INFO: st_nxt.dat = {25'h0, rec_rd.group, 1'b0, rec_rd.event_code};
                REG_REC_REMAIN: st_nxt.dat = 32'(rec_rd.remain);
                REG_REC_ACTIVE: st_nxt.dat = 32'(rec_rd.active);
                REG_REMAIN: st_nxt.dat = 32'(remain);
                default:
                    st_nxt.dat = (wb_adr[7:5] == REG_RELEASE[7:5]) ? 32'(st_r.rel[wb_adr[4:2]]) : '0;
            endcase
        end

        // A new event wins over a clear
        st_nxt.irq_stat = (st_r.irq_stat & ~w1c) | on_raw;
        for (int i = 0; i < 4; i++)
        begin
            if (cclr[i])
                st_nxt.cnt[i] = on_raw[i] ? 16'h0001 : 16'h0000; // R10
            else if (on_raw[i])
                st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001; // R10
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= '0;
            st_r.rel <= {GROUPS{RELEASE_DEF_MS}}; // R3
            st_r.evt_sel <= EVT_SEL_DEF;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb
    begin
        if (st_r.lv[EV_TRIP])
            condition = COND_TRIP; // R8
        else if (st_r.lv[EV_ACTIVE])
            condition = COND_ACTIVE;
        else if (st_r.lv[EV_INIT])
            condition = COND_INIT;
        else if (st_r.lv[EV_BLOCK])
            condition = COND_BLOCKED;
        else
            condition = COND_NORMAL;
    end

    // Test modes report trip but keep contact open
    assign guard_trip = lv_now[EV_TRIP] && !mode_test; // R2
    assign guard_window = st_r.win;
    assign evt_on = st_r.ev_on;
    assign evt_off = st_r.ev_off;
    assign evt_stamp = st_r.ev_stamp;
    assign irq = |(st_r.irq_stat & st_r.irq_mask);
    assign wb_ack = st_r.ack;
    assign wb_rdat = st_r.dat;
endmodule : close_fault_guard

// ==== src/close_fault_guard_pkg.sv ====
// Purpose: Constants, register map and types of the close fault guard
// Assumes: 200 MHz sys_clk, 32-bit classic Wishbone register access
// Notes: Times are in milliseconds
package close_fault_guard_pkg;
    // ****************************************************************
    // Clocking and times
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int CYC_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TW = 21;
    localparam logic [TW-1:0] RELEASE_DEF_MS = 21'h0003e8;
    localparam logic [TW-1:0] RELEASE_MAX_MS = 21'h1b7740;
    localparam int GROUPS = 8;
    localparam int RECORDS = 12;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_TIME = 8'h10;
    localparam logic [7:0] REG_CNT_CLR = 8'h14;
    localparam logic [7:0] REG_CNT_LO = 8'h18;
    localparam logic [7:0] REG_CNT_HI = 8'h1c;
    localparam logic [7:0] REG_REC_SEL = 8'h20;
    localparam logic [7:0] REG_REC_NUM = 8'h24;
    localparam logic [7:0] REG_REC_STAMP = 8'h28;
    localparam logic [7:0] REG_REC_INFO = 8'h2c;
    localparam logic [7:0] REG_REC_REMAIN = 8'h30;
    localparam logic [7:0] REG_REC_ACTIVE = 8'h34;
    localparam logic [7:0] REG_REMAIN = 8'h38;
    localparam logic [7:0] REG_RELEASE = 8'h40;

    // ****************************************************************
    // Control field positions and reset values
    // ****************************************************************
    localparam int CTRL_MODE = 0;
    localparam int CTRL_ALLOW = 3;
    localparam int CTRL_FORCE_EN = 4;
    localparam int CTRL_FORCE = 5;
    localparam int CTRL_EVT_SEL = 7;
    localparam logic [1:0] EVT_SEL_DEF = 2'h3;
    localparam int ST_MODE = 3;
    localparam int ST_WIN = 6;
    localparam int ST_TRIP = 7;
    localparam int ST_SG = 8;
    localparam int INFO_SG = 4;

    // Event bit positions, also irq and counter order
    localparam int EV_INIT = 0;
    localparam int EV_BLOCK = 1;
    localparam int EV_ACTIVE = 2;
    localparam int EV_TRIP = 3;

    typedef enum logic [2:0] {
        MODE_ON = 3'b000,
        MODE_BLOCKED = 3'b001,
        MODE_TEST = 3'b010,
        MODE_TEST_BLOCKED = 3'b011,
        MODE_OFF = 3'b100
    } block_operating_mode_t;

    typedef enum logic [1:0] {
        FORCE_NORMAL = 2'b00,
        FORCE_BLOCKED = 2'b01,
        FORCE_ACTIVE = 2'b10,
        FORCE_TRIP = 2'b11
    } force_status_t;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'b000,
        COND_INIT = 3'b001,
        COND_ACTIVE = 3'b010,
        COND_TRIP = 3'b011,
        COND_BLOCKED = 3'b100
    } condition_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [2:0] event_code;
        logic [2:0] group;
        logic [TW-1:0] remain;
        logic [TW-1:0] active;
    } record_t;
endpackage : close_fault_guard_pkg

// ==== src/ms_tick_gen.sv ====
// Purpose: One-cycle enable pulse once per millisecond
// Assumes: Single sys_clk domain
// Notes: Period is a parameter so simulation can shorten it
`timescale 1ns/10ps
module ms_tick_gen #(
    parameter int CYCLES = 200000
) (
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    output logic tick // Millisecond enable pulse
);
    // ****************************************************************
    // Divider
    // ****************************************************************
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    generate
        if (CYCLES < 1)
        begin : g_bad
            $error("ms_tick_gen: CYCLES must be at least one");
        end
    endgenerate

    logic [CW-1:0] cnt_r;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        end
    end
endmodule : ms_tick_gen

// ==== testbench/close_fault_guard_sva.sv ====
// Purpose: Port assertions of the close fault guard
// Assumes: Single sys_clk domain, reset_n active low
// Notes: Bound into every close_fault_guard instance
`timescale 1ns/10ps
module close_fault_guard_sva
    import close_fault_guard_pkg::*;
#(
    parameter int FUNC_WIDTH = 8
) (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Async reset, active low
    input wire logic wb_cyc, // Bus cycle
    input wire logic wb_stb, // Bus strobe
    input wire logic wb_ack, // Bus acknowledge
    input wire logic arm_in, // Arming input
    input wire logic block_in, // Block input
    input wire logic [FUNC_WIDTH-1:0] func_in, // Stage starts
    input wire logic guard_trip, // Trip output
    input wire logic guard_window, // Window running
    input wire logic [2:0] condition, // Condition code
    input wire logic [3:0] evt_on, // ON pulses
    input wire logic [3:0] evt_off // OFF pulses
);
    // ****************************************************************
    // Sequences and assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence arm_report_s;
        condition == COND_INIT && evt_on[EV_INIT];
    endsequence

    AST_ARM_ON_EDGE: assert property ($rose(guard_window) |->
        $past(arm_in) && !$past(arm_in, 2) && !$past(block_in))
        else $error("Window without arming edge");
    AST_ARM_REPORT: assert property ($rose(guard_window) |=> arm_report_s)
        else $error("Arming not shown");
    AST_TRIP_LEVEL: assert property (guard_window && (|func_in) && guard_trip |=>
        condition == COND_TRIP)
        else $error("Trip not shown");
    AST_TRIP_EVENT: assert property ($rose(condition == COND_TRIP) && guard_window |->
        evt_on[EV_TRIP])
        else $error("No trip ON event");
    AST_EVT_ON_PULSE: assert property (|evt_on |=> (evt_on & $past(evt_on)) == 4'h0)
        else $error("Long ON event");
    AST_EVT_OFF_PULSE: assert property (|evt_off |=> (evt_off & $past(evt_off)) == 4'h0)
        else $error("Long OFF event");
    AST_ACK_TAKEN: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("No ack");
    AST_ACK_ONE: assert property (wb_ack |=> !wb_ack)
        else $error("Long ack");
endmodule : close_fault_guard_sva

bind close_fault_guard close_fault_guard_sva #(.FUNC_WIDTH(FUNC_WIDTH)) u_guard_sva (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack),
    .arm_in(arm_in), .block_in(block_in), .func_in(func_in), .guard_trip(guard_trip),
    .guard_window(guard_window), .condition(condition), .evt_on(evt_on), .evt_off(evt_off));

// ==== testbench/close_fault_guard_tb.sv ====
// Purpose: Self-checking bench of the close fault guard
// Assumes: Millisecond shortened to CPM cycles
// Notes: Reads queue their expectation; a monitor compares at ack
`timescale 1ns/10ps
module close_fault_guard_tb;
    import close_fault_guard_pkg::*;
    localparam int CPM = 10;
    localparam logic [31:0] MODE_ST [0:4] = '{32'h0, 32'hc, 32'h10, 32'h1c, 32'h20};
    logic sys_clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, arm_in, block_in, slow, close_cmd;
    logic guard_trip, guard_window, irq;
    logic [7:0] wb_adr, func_in, fault_cmd;
    logic [3:0] wb_sel, evt_on, evt_off;
    logic [31:0] wb_wdat, wb_rdat, evt_stamp, t;
    logic [31:0] rs = 32'h00005838;
    logic [2:0] setting_group, condition;
    logic [31:0] exp_q [$];
    int miscompares = 0;
    int total_checks = 0;

    close_fault_guard #(.FUNC_WIDTH(8), .CYCLES_PER_MS(CPM)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .wb_adr(wb_adr), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(wb_sel),
        .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack), .arm_in(arm_in), .block_in(block_in),
        .func_in(func_in), .setting_group(setting_group), .guard_trip(guard_trip),
        .guard_window(guard_window), .condition(condition), .evt_on(evt_on), .evt_off(evt_off),
        .evt_stamp(evt_stamp), .irq(irq));
    close_logic_model u_close (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .close_cmd(close_cmd),
        .fault_cmd(fault_cmd), .arm_in(arm_in), .func_in(func_in));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // Holds request until ack, idles one cycle
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] exp);
        if (!we)
            exp_q.push_back(exp);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= dat;
        do
            @(posedge sys_clk);
        while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb_io

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_io(1'b1, a, d, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb_io(1'b0, a, 32'h0, e);
    endtask : rd

    task automatic arm_and_wait(input logic exp_open);
        int n;
        n = 0;
        close_cmd <= 1'b1;
        while (guard_window !== 1'b1 && n < 6)
        begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0, guard_window}, {31'h0, exp_open});
    endtask : arm_and_wait

    task automatic win_len(output int len);
        len = 0;
        while (guard_window === 1'b1 && len < 20000)
        begin
            @(posedge sys_clk);
            len++;
        end
    endtask : win_len

    // Free tick phase: one ms slack below
    task automatic chk_len(input int len, input logic [31:0] r);
        check({31'h0, len >= (r - 1) * CPM - 2 && len <= r * CPM + 2}, 32'h1);
    endtask : chk_len

    task automatic settle();
        int len;
        close_cmd <= 1'b0;
        fault_cmd <= 8'h00;
        win_len(len);
        cyc(3);
    endtask : settle

    always @(posedge sys_clk)
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
            check(wb_rdat, exp_q.pop_front());

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        cyc(20000);
        miscompares++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] r0;
        int len;
        reset_n = 1'b0;
        {wb_cyc, wb_stb, wb_we, block_in, slow, close_cmd} = 6'h00;
        wb_sel = 4'hf;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        fault_cmd = 8'h00;
        setting_group = 3'h0;
        cyc(2);
        reset_n <= 1'b1;
        cyc(1);
        rd(REG_CTRL, 32'h180);
        rd(REG_RELEASE + 8'h1c, {11'h0, RELEASE_DEF_MS});
        rd(8'h3c, 32'h0);
        wr(REG_RELEASE, 32'h1fffff);
        rd(REG_RELEASE, {11'h0, RELEASE_MAX_MS});
        r0 = 32'h3 + rnd() % 32'h3;
        wr(REG_RELEASE, r0);
        wr(REG_RELEASE + 8'h04, 32'h1);
        arm_and_wait(1'b1);
        win_len(len);
        chk_len(len, r0);
        cyc(20);
        check({31'h0, guard_window}, 32'h0);
        settle();
        arm_and_wait(1'b1);
        cyc(15);
        close_cmd <= 1'b0;
        cyc(2);
        close_cmd <= 1'b1;
        cyc(2);
        win_len(len);
        chk_len(len, r0);
        settle();
        arm_and_wait(1'b1);
        cyc(12);
        setting_group <= 3'h1;
        cyc(3);
        check({31'h0, guard_window}, 32'h0);
        setting_group <= 3'h0;
        settle();
        wr(REG_CNT_CLR, 32'hf);
        wr(REG_IRQ_STAT, 32'hf);
        for (int i = 0; i < 3; i++)
        begin
            slow <= (i == 1);
            arm_and_wait(1'b1);
            check({31'h0, guard_trip}, 32'h0);
            t = rnd();
            fault_cmd <= (t[7:0] == 8'h00) ? 8'h5a : t[7:0];
            cyc(1);
            #1;
            check({31'h0, guard_trip}, 32'h1);
            cyc(3);
            check({29'h0, condition}, {29'h0, COND_TRIP});
            settle();
        end
        rd(REG_CNT_LO, 32'h3);
        rd(REG_CNT_HI, 32'h00030003);
        rd(REG_IRQ_STAT, 32'hd);
        check({31'h0, irq}, 32'h0);
        wr(REG_IRQ_MASK, 32'h4);
        check({31'h0, irq}, 32'h1);
        wr(REG_IRQ_STAT, 32'h4);
        check({31'h0, irq}, 32'h0);
        wr(REG_CNT_CLR, 32'h1);
        rd(REG_CNT_LO, 32'h0);
        wr(REG_REC_SEL, 32'h0);
        rd(REG_REC_INFO, 32'h3);
        block_in <= 1'b1;
        arm_and_wait(1'b0);
        check({29'h0, condition}, {29'h0, COND_BLOCKED});
        rd(REG_REC_INFO, 32'h4);
        block_in <= 1'b0;
        settle();
        for (int i = 0; i < 5; i++)
        begin
            wr(REG_CTRL, 32'h188);
            wr(REG_CTRL, 32'h188 | i[31:0]);
            rd(REG_STATUS, MODE_ST[i]);
            arm_and_wait(i == 0 || i == 2);
            fault_cmd <= 8'h01;
            cyc(1);
            #1;
            check({31'h0, guard_trip}, {31'h0, i == 0});
            settle();
        end
        wr(REG_CTRL, 32'h1f0);
        check({31'h0, guard_trip}, 32'h1);
        check({29'h0, condition}, {29'h0, COND_TRIP});
        wr(REG_CTRL, 32'h190);
        check({31'h0, guard_trip}, 32'h0);
        wr(REG_CTRL, 32'h180);
        rd(REG_REC_NUM, 32'hc);
        end_of_test();
    end
endmodule : close_fault_guard_tb

// ==== testbench/close_logic_model.sv ====
// Purpose: Close logic and stage starts feeding the guard
// Assumes: Single sys_clk domain
// Notes: Slow mode adds one cycle of close lag
`timescale 1ns/10ps
module close_logic_model (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Async reset, active low
    input wire logic slow, // Extra close lag
    input wire logic close_cmd, // Close request
    input wire logic [7:0] fault_cmd, // Stage starts
    output logic arm_in, // Arming input
    output logic [7:0] func_in // To the guard
);
    logic close_dly_r;
    logic arm_r;
    logic [7:0] func_r;

    always_ff @(posedge sys_clk)
    begin
        close_dly_r <= close_cmd;
        arm_r <= slow ? close_dly_r : close_cmd;
        func_r <= fault_cmd;
    end

    // Quiet in reset: no unknowns at the guard
    assign arm_in = reset_n ? arm_r : 1'b0;
    assign func_in = reset_n ? func_r : 8'h00;
endmodule : close_logic_model
